// *** dmx_pkg.sv ***
// Purpose: Shared constants, types and register map of the four-channel transfer engine.
// Assumes: Register index times four gives the APB byte address.
// Notes: Control and status bit positions are laid out here once.
package dmx_pkg;

  localparam int DMX_CH = 4;
  localparam int DMX_AW = 24;
  localparam int DMX_LW = 16;
  localparam int DMX_PAW = 9;

  // Register indices inside one channel; channel number sits above them
  localparam logic [4:0] DMX_IDX_ADDR_A = 5'h00;
  localparam logic [4:0] DMX_IDX_ADDR_B = 5'h08;
  localparam logic [4:0] DMX_IDX_LENGTH = 5'h10;
  localparam logic [4:0] DMX_IDX_CONTROL = 5'h1c;
  localparam logic [4:0] DMX_IDX_STATUS = 5'h1e;

  // Control word bit positions
  localparam int DMX_C_ENABLE = 0;
  localparam int DMX_C_WAY = 1;
  localparam int DMX_C_SIZE = 2;
  localparam int DMX_C_INDIRECT = 3;
  localparam int DMX_C_CONT = 4;
  localparam int DMX_C_AUTOINIT = 5;
  localparam int DMX_C_STEP_A = 8;
  localparam int DMX_C_ADJ_A = 10;
  localparam int DMX_C_STEP_B = 12;
  localparam int DMX_C_ADJ_B = 14;
  localparam int DMX_C_IRQ_TC = 16;
  localparam int DMX_C_IRQ_OVR = 17;
  localparam int DMX_C_SECONDARY = 18;
  localparam logic [31:0] DMX_CTRL_MASK = 32'h0007_773f;

  // Status word bit positions
  localparam int DMX_S_TC = 0;
  localparam int DMX_S_OVR = 1;
  localparam int DMX_S_ACTIVE = 2;
  localparam int DMX_S_VALID = 3;

  // Reset values
  localparam logic [31:0] DMX_CTRL_RST = 32'h0000_0000;
  localparam logic [23:0] DMX_ADDR_RST = 24'h00_0000;
  localparam logic [15:0] DMX_LEN_RST = 16'h0000;

  // Step field codes
  localparam logic [1:0] DMX_STEP_INC1 = 2'h0;
  localparam logic [1:0] DMX_STEP_INC2 = 2'h1;
  localparam logic [1:0] DMX_STEP_DEC1 = 2'h2;
  localparam logic [1:0] DMX_STEP_DEC2 = 2'h3;

  typedef enum logic [5:0] {
    DMX_IDLE = 6'b000001,
    DMX_ARB = 6'b000010,
    DMX_XFER = 6'b000100,
    DMX_WRITE = 6'b001000,
    DMX_REL = 6'b010000,
    DMX_GAP = 6'b100000
  } dmx_state_t;

  typedef struct packed {
    logic serial_rx;
    logic serial_tx;
    logic audio_rx;
    logic audio_tx;
    logic pcm_out;
    logic pcm_in;
  } dmx_periph_t;

  typedef struct packed {
    logic [23:0] addr;
    logic rd;
    logic wr;
    logic wide;
  } dmx_bus_t;

endpackage

// *** dmx_addr_step.sv ***
// Purpose: Next value of one address counter after a transferred item.
// Assumes: Step size is independent of item size.
// Notes: Adjust off freezes the address.
`timescale 1ns/1ps
module dmx_addr_step
  import dmx_pkg::*;
(
  input wire logic [23:0] addr,
  input wire logic [1:0] step,
  input wire logic adjust,
  output logic [23:0] addr_next
);

  wire [23:0] delta = (step == DMX_STEP_INC2 || step == DMX_STEP_DEC2) ? 24'h00_0002 : 24'h00_0001;
  wire down = (step == DMX_STEP_DEC1) || (step == DMX_STEP_DEC2);

  assign addr_next = !adjust ? addr : (down ? addr - delta : addr + delta);

endmodule

// *** dmx_engine.sv ***
// Purpose: Four-channel transfer engine with an APB register slave and a system bus master.
// Assumes: Peripheral requests, grant and freeze come from logic on pclk.
// Notes: Bus cycles take one clock; data is valid in the cycle of the strobe.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module dmx_engine
  import dmx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dmx_periph_t periph_req,
  output dmx_periph_t periph_ack,
  output logic bus_req,
  input wire logic bus_grant,
  input wire logic freeze,
  output dmx_bus_t sys_bus,
  input wire logic [15:0] sys_rdata,
  output logic [15:0] sys_wdata,
  output logic [3:0] chan_irq
);

  logic [23:0] addr_a_reg [DMX_CH];
  logic [23:0] addr_b_reg [DMX_CH];
  logic [15:0] len_reg [DMX_CH];
  logic [31:0] ctrl_reg [DMX_CH];
  logic [3:0] tc_reg;
  logic [3:0] ovr_reg;
  logic [3:0] active_reg;
  logic [3:0] valid_reg;
  logic [3:0] irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  dmx_state_t state_reg;
  dmx_state_t state_next;
  logic [1:0] cur_ch_reg;
  logic [15:0] temp_reg;
  dmx_bus_t bus_reg;
  dmx_bus_t bus_next;
  dmx_periph_t ack_reg;
  dmx_periph_t ack_next;
  logic bus_req_reg;

  // APB decode
  wire [1:0] apb_ch = paddr[8:7];
  wire [4:0] apb_idx = paddr[6:2];
  wire hit_a = (apb_idx == DMX_IDX_ADDR_A);
  wire hit_b = (apb_idx == DMX_IDX_ADDR_B);
  wire hit_len = (apb_idx == DMX_IDX_LENGTH);
  wire hit_ctrl = (apb_idx == DMX_IDX_CONTROL);
  wire hit_stat = (apb_idx == DMX_IDX_STATUS);
  wire mapped = hit_a | hit_b | hit_len | hit_ctrl | hit_stat;
  wire apb_done = psel & penable & pready_reg;
  wire apb_wr = apb_done & pwrite & mapped;

  wire [31:0] stat_word = {28'h000_0000, valid_reg[apb_ch], active_reg[apb_ch],
                           ovr_reg[apb_ch], tc_reg[apb_ch]};
  wire [31:0] rd_word = hit_a ? {8'h00, addr_a_reg[apb_ch]} :
                        hit_b ? {8'h00, addr_b_reg[apb_ch]} :
                        hit_len ? {16'h0000, len_reg[apb_ch]} :
                        hit_ctrl ? ctrl_reg[apb_ch] :
                        hit_stat ? stat_word : 32'h0000_0000;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= psel & penable & !pready_reg;
      prdata_reg <= (psel & penable & !pready_reg & !pwrite) ? rd_word : 32'h0000_0000;
      pslverr_reg <= psel & penable & !pready_reg & !mapped;
    end
  end

  // Request routing per channel
  wire [3:0] sec;
  wire [3:0] en;
  wire [3:0] route_req;
  wire [3:0] pend;
  generate
    for (genvar c = 0; c < DMX_CH; c++)
    begin : g_sel
      assign sec[c] = ctrl_reg[c][DMX_C_SECONDARY];
      assign en[c] = ctrl_reg[c][DMX_C_ENABLE];
      assign pend[c] = en[c] & active_reg[c] & route_req[c] & !freeze;
    end
  endgenerate
  assign route_req[0] = sec[0] & periph_req.serial_rx;
  assign route_req[1] = !sec[1] & periph_req.serial_tx;
  assign route_req[2] = sec[2] ? periph_req.pcm_out : periph_req.audio_rx;
  assign route_req[3] = sec[3] ? periph_req.pcm_in : periph_req.audio_tx;

  wire any_pend = |pend;
  wire [1:0] win_ch = pend[0] ? 2'd0 : pend[1] ? 2'd1 : pend[2] ? 2'd2 : 2'd3;

  // Fields of the channel being serviced
  wire [31:0] cur_ctrl = ctrl_reg[cur_ch_reg];
  wire cur_way = cur_ctrl[DMX_C_WAY];
  wire cur_ind = cur_ctrl[DMX_C_INDIRECT];
  wire cur_cont = cur_ctrl[DMX_C_CONT];
  wire cur_wide = cur_ctrl[DMX_C_SIZE];
  wire cur_last = (len_reg[cur_ch_reg] == 16'h0001);
  wire cur_more = pend[cur_ch_reg] & !cur_last;
  wire item_done = ((state_reg == DMX_XFER) & !cur_ind) | (state_reg == DMX_WRITE);

  wire [23:0] step_a_out;
  wire [23:0] step_b_out;

  dmx_addr_step u_step_a (
    .addr(addr_a_reg[cur_ch_reg]),
    .step(cur_ctrl[DMX_C_STEP_A +: 2]),
    .adjust(cur_ctrl[DMX_C_ADJ_A]),
    .addr_next(step_a_out)
  );

  dmx_addr_step u_step_b (
    .addr(addr_b_reg[cur_ch_reg]),
    .step(cur_ctrl[DMX_C_STEP_B +: 2]),
    .adjust(cur_ctrl[DMX_C_ADJ_B] & cur_ind),
    .addr_next(step_b_out)
  );

  // Address seen by the next bus cycle, already stepped when an item just ended
  wire [23:0] a_now = item_done ? step_a_out : addr_a_reg[cur_ch_reg];
  wire [23:0] b_now = item_done ? step_b_out : addr_b_reg[cur_ch_reg];

  // Per-channel registers and flags
  generate
    for (genvar c = 0; c < DMX_CH; c++)
    begin : g_ch
      wire sel = (apb_ch == 2'(c));
      wire upd = item_done & (cur_ch_reg == 2'(c));
      wire term = upd & cur_last;
      wire wr_stat = apb_wr & sel & hit_stat;

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          addr_a_reg[c] <= DMX_ADDR_RST;
          addr_b_reg[c] <= DMX_ADDR_RST;
          len_reg[c] <= DMX_LEN_RST;
          ctrl_reg[c] <= DMX_CTRL_RST;
        end
        else
        begin
          if (upd)
            addr_a_reg[c] <= step_a_out;
          else if (apb_wr & sel & hit_a)
            addr_a_reg[c] <= pwdata[23:0];
          if (upd & cur_ind)
            addr_b_reg[c] <= step_b_out;
          else if (apb_wr & sel & hit_b)
            addr_b_reg[c] <= pwdata[23:0];
          if (upd)
            len_reg[c] <= len_reg[c] - 16'h0001;
          else if (apb_wr & sel & hit_len)
            len_reg[c] <= pwdata[15:0];
          if (apb_wr & sel & hit_ctrl)
            ctrl_reg[c] <= pwdata & DMX_CTRL_MASK;
        end
      end

      // Hardware set wins over a software clear in the same cycle
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tc_reg[c] <= 1'b0;
          ovr_reg[c] <= 1'b0;
          active_reg[c] <= 1'b0;
          valid_reg[c] <= 1'b0;
          irq_reg[c] <= 1'b0;
        end
        else
        begin
          if (term)
            tc_reg[c] <= 1'b1;
          else if (wr_stat & pwdata[DMX_S_TC])
            tc_reg[c] <= 1'b0;
          if (term)
            ovr_reg[c] <= 1'b1;
          else if (wr_stat & pwdata[DMX_S_OVR])
            ovr_reg[c] <= 1'b0;
          if (wr_stat & pwdata[DMX_S_VALID])
            valid_reg[c] <= 1'b0;
          if (term | !en[c])
            active_reg[c] <= 1'b0;
          else if (len_reg[c] != 16'h0000)
            active_reg[c] <= 1'b1;
          irq_reg[c] <= (tc_reg[c] & ctrl_reg[c][DMX_C_IRQ_TC]) |
                        (ovr_reg[c] & ctrl_reg[c][DMX_C_IRQ_OVR]);
        end
      end
    end
  endgenerate

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DMX_IDLE:
        if (any_pend)
          state_next = DMX_ARB;
      DMX_ARB:
        if (!any_pend)
          state_next = DMX_IDLE;
        else if (bus_grant)
          state_next = DMX_XFER;
      DMX_XFER:
        if (cur_ind)
          state_next = DMX_WRITE;
        else if (cur_cont & cur_more)
          state_next = DMX_XFER;
        else
          state_next = DMX_REL;
      DMX_WRITE:
        if (cur_cont & cur_more)
          state_next = DMX_XFER;
        else
          state_next = DMX_REL;
      DMX_REL:
        if (cur_ind)
          state_next = DMX_GAP;
        else if (any_pend)
          state_next = DMX_ARB;
        else
          state_next = DMX_IDLE;
      DMX_GAP:
        state_next = any_pend ? DMX_ARB : DMX_IDLE;
      default:
        state_next = DMX_IDLE;
    endcase
  end

  wire nx_xfer = (state_next == DMX_XFER);
  wire nx_write = (state_next == DMX_WRITE);
  wire nx_ind = cur_ctrl[DMX_C_INDIRECT];

  always_comb
  begin
    bus_next.rd = nx_xfer & (nx_ind | !cur_way);
    bus_next.wr = (nx_xfer & !nx_ind & cur_way) | nx_write;
    bus_next.wide = (nx_xfer | nx_write) & cur_wide;
    if (nx_write)
      bus_next.addr = cur_way ? a_now : b_now;
    else if (nx_xfer)
      bus_next.addr = (nx_ind & cur_way) ? b_now : a_now;
    else
      bus_next.addr = 24'h00_0000;
  end

  // Acknowledge goes to the requesting peripheral in the cycle that touches it
  wire ack_on = (nx_xfer & !nx_ind) | nx_write;
  wire [3:0] ack_ch = ack_on ? (4'h1 << cur_ch_reg) : 4'h0;
  always_comb
  begin
    ack_next.serial_rx = ack_ch[0] & sec[0];
    ack_next.serial_tx = ack_ch[1] & !sec[1];
    ack_next.audio_rx = ack_ch[2] & !sec[2];
    ack_next.pcm_out = ack_ch[2] & sec[2];
    ack_next.audio_tx = ack_ch[3] & !sec[3];
    ack_next.pcm_in = ack_ch[3] & sec[3];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= DMX_IDLE;
      cur_ch_reg <= 2'd0;
      bus_reg <= '0;
      ack_reg <= '0;
      bus_req_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next == DMX_ARB)
        cur_ch_reg <= win_ch;
      bus_reg <= bus_next;
      ack_reg <= ack_next;
      bus_req_reg <= (state_next == DMX_ARB) | nx_xfer | nx_write;
    end
  end

  // Temporary register of indirect mode; drives write data in the next cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      temp_reg <= 16'h0000;
    else if ((state_reg == DMX_XFER) & cur_ind)
      temp_reg <= cur_wide ? sys_rdata : {8'h00, sys_rdata[7:0]};
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign periph_ack = ack_reg;
  assign bus_req = bus_req_reg;
  assign sys_bus = bus_reg;
  assign sys_wdata = temp_reg;
  assign chan_irq = irq_reg;

endmodule

// *** dmx_engine_monitor.sv ***
// Purpose: Concurrent checks on the transfer engine ports.
// Assumes: One clock domain, reset active low.
// Notes: Bound to every engine instance.
`timescale 1ns/1ps
module dmx_engine_monitor
  import dmx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [8:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire dmx_periph_t periph_req,
  input wire dmx_periph_t periph_ack,
  input wire logic bus_req,
  input wire logic bus_grant,
  input wire logic freeze,
  input wire dmx_bus_t sys_bus,
  input wire logic [15:0] sys_rdata,
  input wire logic [15:0] sys_wdata,
  input wire logic [3:0] chan_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic stb = sys_bus.rd | sys_bus.wr;
  wire logic [4:0] idx = paddr[6:2];
  property p_single; !(sys_bus.rd && sys_bus.wr); endproperty
  a_single: assert property (p_single)
    else $error("read and write strobe together");
  property p_grant; stb |-> $past(bus_grant) && $past(bus_req); endproperty
  a_grant: assert property (p_grant)
    else $error("strobe without bus ownership");
  property p_ack; (periph_ack != 6'h00) |-> stb; endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge outside a bus cycle");
  property p_onehot; $onehot0(periph_ack); endproperty
  a_onehot: assert property (p_onehot)
    else $error("several peripherals served at once");
  property p_route; (periph_ack != 6'h00) |-> ((periph_ack & $past(periph_req)) != 6'h00);
  endproperty
  a_route: assert property (p_route)
    else $error("acknowledge to a silent source");
  property p_freeze; freeze [*4] |-> !stb; endproperty
  a_freeze: assert property (p_freeze)
    else $error("bus cycle while frozen");
  property p_upper;
    (pready && !pwrite && (idx == DMX_IDX_ADDR_A || idx == DMX_IDX_ADDR_B))
      |-> prdata[31:24] == 8'h00;
  endproperty
  a_upper: assert property (p_upper)
    else $error("address counter upper byte not zero");
  property p_temp;
    sys_bus.rd ##1 sys_bus.wr
      |-> sys_wdata == (sys_bus.wide ? $past(sys_rdata) : ($past(sys_rdata) & 16'h00ff));
  endproperty
  a_temp: assert property (p_temp)
    else $error("written item differs from item read");
  c_direct: cover property (stb && (periph_ack != 6'h00) && bus_req);
  c_pair: cover property (sys_bus.rd ##1 sys_bus.wr);
  c_irq: cover property ($rose(chan_irq != 4'h0));
endmodule

bind dmx_engine dmx_engine_monitor u_dmx_engine_monitor (.pclk, .presetn, .pwrite, .paddr,
  .prdata, .pready, .periph_req, .periph_ack, .bus_req, .bus_grant, .freeze, .sys_bus,
  .sys_rdata, .sys_wdata, .chan_irq);

// *** dmx_bus_model.sv ***
// Purpose: Far side of the system bus: grant and read data.
// Assumes: One engine master on pclk.
// Notes: Idle data lines show the inverse of the last value.
`timescale 1ns/1ps
module dmx_bus_model
  import dmx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic bus_req,
  input wire dmx_bus_t sys_bus,
  output logic bus_grant,
  output logic [15:0] sys_rdata
);
  logic [1:0] wait_reg;
  logic [15:0] last_reg;
  wire logic [15:0] item = {sys_bus.addr[7:0] ^ 8'ha5, sys_bus.addr[7:0]};
  // Slow arbiter grants after three waits
  assign bus_grant = bus_req && (!slow || wait_reg == 2'h3);
  assign sys_rdata = sys_bus.rd ? item : ~last_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_reg <= 2'h0;
      last_reg <= 16'h0000;
    end
    else
    begin
      wait_reg <= !bus_req ? 2'h0 : (wait_reg == 2'h3 ? wait_reg : wait_reg + 2'h1);
      last_reg <= sys_rdata;
    end
  end
endmodule

// *** dmx_engine_bench.sv ***
// Purpose: Self-checking bench for the transfer engine.
// Assumes: APB master tasks, bus model on the far side.
// Notes: Strobes are logged and compared item by item.
`timescale 1ns/1ps
module dmx_engine_bench
  import dmx_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic freeze = 1'b0, slow = 1'b0;
  logic [8:0] paddr = 9'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, bus_req, bus_grant;
  dmx_periph_t periph_req = 6'h00, periph_ack;
  dmx_bus_t sys_bus;
  logic [15:0] sys_rdata, sys_wdata;
  logic [3:0] chan_irq;
  int n_errors = 0, n_checks = 0, cyc = 0;
  int q_cyc[$];
  dmx_bus_t q_bus[$];
  dmx_periph_t q_ack[$];
  logic [15:0] q_wd[$];
  dmx_engine u_dmx_engine (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .periph_req, .periph_ack, .bus_req, .bus_grant, .freeze,
    .sys_bus, .sys_rdata, .sys_wdata, .chan_irq);
  dmx_bus_model u_dmx_bus_model (.pclk, .presetn, .slow, .bus_req, .sys_bus, .bus_grant,
    .sys_rdata);
  always #50 pclk = ~pclk;
  task end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (sys_bus.rd === 1'b1 || sys_bus.wr === 1'b1)
    begin
      q_cyc.push_back(cyc);
      q_bus.push_back(sys_bus);
      q_ack.push_back(periph_ack);
      q_wd.push_back(sys_wdata);
    end
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [8:0] ra(input int ch, input logic [4:0] idx);
    return 9'(ch * 128 + idx * 4);
  endfunction
  task apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rchk(input string nm, input int ch, input logic [4:0] idx, input logic [31:0] exp);
    apb(1'b0, ra(ch, idx), 32'h0);
    chk(nm, rd, exp);
  endtask
  task setup(input int ch, input logic [31:0] c, input logic [15:0] n);
    apb(1'b1, ra(ch, DMX_IDX_CONTROL), c);
    apb(1'b1, ra(ch, DMX_IDX_ADDR_A), 32'h0000_1000);
    apb(1'b1, ra(ch, DMX_IDX_ADDR_B), 32'h0000_2000);
    apb(1'b1, ra(ch, DMX_IDX_LENGTH), {16'h0000, n});
    apb(1'b1, ra(ch, DMX_IDX_STATUS), 32'h0000_000f);
    apb(1'b1, ra(ch, DMX_IDX_CONTROL), c | 32'h1);
    q_cyc.delete();
    q_bus.delete();
    q_ack.delete();
    q_wd.delete();
  endtask
  task wait_idle(input int ch);
    rd = 32'h4;
    while (rd[DMX_S_ACTIVE] === 1'b1)
      apb(1'b0, ra(ch, DMX_IDX_STATUS), 32'h0);
  endtask
  task close_ch(input int ch, input logic [31:0] c);
    periph_req <= 6'h00;
    apb(1'b1, ra(ch, DMX_IDX_CONTROL), c);
    rchk("length", ch, DMX_IDX_LENGTH, 32'h0);
    rchk("status", ch, DMX_IDX_STATUS, 32'h3);
    chk("irq", 32'(chan_irq[ch]), 32'(c[DMX_C_IRQ_TC] | c[DMX_C_IRQ_OVR]));
    apb(1'b1, ra(ch, DMX_IDX_STATUS), 32'hf);
    rchk("status clear", ch, DMX_IDX_STATUS, 32'h0);
    chk("irq clear", 32'(chan_irq[ch]), 32'h0);
  endtask
  task go(input int ch, input logic [31:0] c, input logic [15:0] n, input dmx_periph_t rq,
    input int gap, input int da, input int db);
    int k;
    int m;
    int i;
    int j;
    logic [15:0] w;
    dmx_bus_t e;
    setup(ch, c, n);
    rchk("active", ch, DMX_IDX_STATUS, 32'h4);
    periph_req <= rq;
    wait_idle(ch);
    close_ch(ch, c);
    m = c[DMX_C_INDIRECT] ? 2 : 1;
    chk("items", q_bus.size(), n * m);
    for (k = 0; k < q_bus.size(); k++)
    begin
      i = ((m == 1) || ((k % m == 0) != c[DMX_C_WAY])) ? 32'h1000 + da * (k / m)
        : 32'h2000 + db * (k / m);
      e.addr = 24'(i);
      e.rd = (m == 1) ? !c[DMX_C_WAY] : (k % m == 0);
      e.wr = !e.rd;
      e.wide = c[DMX_C_SIZE];
      chk("bus", 32'(q_bus[k]), 32'(e));
      chk("ack", 32'(q_ack[k]), (k % m == m - 1) ? 32'(rq) : 32'h0);
      if (m == 2 && k % m == 1)
      begin
        // Item the bus model returned for the read half of this pair
        j = c[DMX_C_WAY] ? 32'h2000 + db * (k / m) : 32'h1000 + da * (k / m);
        w = {j[7:0] ^ 8'ha5, j[7:0]};
        chk("wdata", 32'(q_wd[k]), c[DMX_C_SIZE] ? 32'(w) : 32'(w[7:0]));
      end
      if (gap != 0 && k >= m && k % m == 0)
        chk("gap", q_cyc[k] - q_cyc[k - m], gap);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("ctrl reset", 1, DMX_IDX_CONTROL, DMX_CTRL_RST);
    rchk("status reset", 1, DMX_IDX_STATUS, 32'h0);
    apb(1'b1, ra(1, DMX_IDX_CONTROL), 32'hffff_fffe);
    rchk("ctrl bits", 1, DMX_IDX_CONTROL, 32'hffff_fffe & DMX_CTRL_MASK);
    apb(1'b1, ra(1, DMX_IDX_CONTROL), 32'h0);
    apb(1'b1, ra(2, DMX_IDX_ADDR_A), 32'hffff_ffff);
    rchk("addr a", 2, DMX_IDX_ADDR_A, 32'h00ff_ffff);
    apb(1'b0, ra(2, 5'h04), 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    go(0, 32'h0005_0404, 16'h3, 6'b100000, 3, 1, 0);
    go(1, 32'h0002_0712, 16'h3, 6'b010000, 1, -2, 0);
    go(3, 32'h0001_650c, 16'h2, 6'b000100, 5, 2, -1);
    go(2, 32'h0005_401a, 16'h2, 6'b000010, 2, 0, 1);
    slow <= 1'b1;
    go(2, 32'h0001_0004, 16'h1, 6'b001000, 0, 0, 0);
    slow <= 1'b0;
    freeze <= 1'b1;
    setup(3, 32'h0004_0006, 16'h1);
    setup(0, 32'h0004_0000, 16'h1);
    periph_req <= 6'b100001;
    rchk("frozen", 0, DMX_IDX_STATUS, 32'h4);
    chk("frozen items", q_bus.size(), 0);
    freeze <= 1'b0;
    wait_idle(3);
    chk("first", 32'(q_ack[0]), 32'h20);
    chk("second", 32'(q_ack[1]), 32'h01);
    close_ch(0, 32'h0004_0000);
    close_ch(3, 32'h0004_0006);
    end_sim();
  end
endmodule
